// >>> core/two_level_interrupt_prioritizer.sv
// two-level vectored interrupt prioritizer with level registers
`timescale 1ns/1ps
module two_level_interrupt_prioritizer
    import prio_pkg::*;
#(
    parameter int PCA_MODULES = PCA_MODULES_DEF
)
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrWr,
    input wire logic sfrRd,
    output logic [7:0] sfrRdData,
    input wire logic [NUM_SRC-1:0] srcPending,
    input wire logic [NUM_SRC-1:0] srcEnable,
    input wire logic [PCA_MODULES-1:0] pcaMatch,
    input wire logic [CMP_COUNT-1:0] cmpOut,
    input wire logic [CMP_FLAGS-1:0] cmpFlagClear,
    input wire logic callAck,
    input wire logic returnDone,
    input wire logic instrDone,
    output logic callReq,
    output logic [15:0] callVector,
    output logic callHigh,
    output logic [CMP_FLAGS-1:0] cmpFlags,
    output logic wakeReq,
    output logic inServiceLow,
    output logic inServiceHigh
);

    // ***************************************************************
    // level registers
    // ***************************************************************
    logic [BASIC_BITS-1:0] basicLevel;
    logic [7:0] ext1Level;
    logic [7:0] ext2Level;
    logic holdOff;

    wire logic wrBasic;
    wire logic wrExt1;
    wire logic wrExt2;
    wire logic [7:0] rdMux;
    wire logic [7:0] statusWord;

    assign wrBasic = sfrWr && (sfrAddr == BASIC_PRIO_ADDR);
    assign wrExt1 = sfrWr && (sfrAddr == EXT_PRIO1_ADDR);
    assign wrExt2 = sfrWr && (sfrAddr == EXT_PRIO2_ADDR);
    assign statusWord = {5'h00, holdOff, inServiceHigh, inServiceLow};
    assign rdMux =
        (sfrAddr == BASIC_PRIO_ADDR) ? {BASIC_UNUSED_READ, basicLevel} :
        (sfrAddr == EXT_PRIO1_ADDR) ? ext1Level :
        (sfrAddr == EXT_PRIO2_ADDR) ? ext2Level :
        (sfrAddr == SVC_STATUS_ADDR) ? statusWord : 8'h00;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            basicLevel <= BASIC_RESET;
            ext1Level <= EXT_RESET;
            ext2Level <= EXT_RESET;
        end
        else
        begin
            if (wrBasic)
                basicLevel <= sfrWrData[BASIC_BITS-1:0];
            if (wrExt1)
                ext1Level <= sfrWrData;
            if (wrExt2)
                ext2Level <= sfrWrData;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            sfrRdData <= 8'h00;
        else
            sfrRdData <= sfrRd ? rdMux : 8'h00;
    end

    // ***************************************************************
    // comparator edge requests
    // ***************************************************************
    logic [CMP_COUNT-1:0] cmpPrev;
    wire logic [CMP_FLAGS-1:0] cmpSet;
    wire logic [CMP_FLAGS-1:0] next_cmpFlags;

    genvar c;
    generate
        for (c = 0; c < CMP_COUNT; c++)
        begin : g_cmp
            // falling edge takes the earlier position
            assign cmpSet[2*c] = cmpPrev[c] & ~cmpOut[c];
            assign cmpSet[2*c+1] = ~cmpPrev[c] & cmpOut[c];
        end
    endgenerate

    // a new edge wins over a clear in the same cycle
    assign next_cmpFlags = cmpSet | (cmpFlags & ~cmpFlagClear);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmpPrev <= '0;
            cmpFlags <= '0;
        end
        else
        begin
            cmpPrev <= cmpOut;
            cmpFlags <= next_cmpFlags;
        end
    end

    // ***************************************************************
    // request vector and arbitration
    // ***************************************************************
    arb_if arb ();

    vector_arbiter u_arbiter (
        .arb(arb)
    );

    wire logic [NUM_SRC-1:0] pendingAll;

    genvar s;
    generate
        for (s = 0; s < NUM_SRC; s++)
        begin : g_src
            if (s == PCA_SRC)
            begin : g_pca
                // overflow and match flags share one vector
                assign pendingAll[s] = srcPending[s] | (|pcaMatch);
            end
            else if (s >= CMP_SRC_FIRST && s < CMP_SRC_FIRST + CMP_FLAGS)
            begin : g_cmpsrc
                assign pendingAll[s] = cmpFlags[s - CMP_SRC_FIRST];
            end
            else if (s == UNUSED_SRC)
            begin : g_unused
                assign pendingAll[s] = 1'b0;
            end
            else
            begin : g_plain
                assign pendingAll[s] = srcPending[s];
            end
        end
    endgenerate

    assign arb.req = pendingAll & srcEnable;
    // ext1 sits on top of the basic bits, ext2 above it
    assign arb.level = {ext2Level, ext1Level, basicLevel};

    // ***************************************************************
    // service tracking and call request
    // ***************************************************************
    wire logic eligible;
    wire logic [15:0] winVector;
    wire logic next_wake;

    // only a high request may nest into a low service
    assign eligible = arb.found && !inServiceHigh && !holdOff
        && (!inServiceLow || arb.winHigh) && !callAck
        && !returnDone;
    assign winVector = vector_of(arb.winIdx);
    assign next_wake = |(cmpFlags &
        srcEnable[CMP_SRC_FIRST +: CMP_FLAGS]);

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            callReq <= 1'b0;
            callVector <= RESET_VECTOR;
            callHigh <= 1'b0;
            wakeReq <= 1'b0;
        end
        else
        begin
            // callReq is refreshed every cycle, vector and level only when eligible
            callReq <= eligible;
            if (eligible)
            begin
                callVector <= winVector;
                callHigh <= arb.winHigh;
            end
            wakeReq <= next_wake;
        end
    end

    // the return pops the most recent level, then one instruction runs
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            inServiceLow <= 1'b0;
            inServiceHigh <= 1'b0;
            holdOff <= 1'b0;
        end
        else if (returnDone)
        begin
            if (inServiceHigh)
                inServiceHigh <= 1'b0;
            else
                inServiceLow <= 1'b0;
            holdOff <= 1'b1;
        end
        else
        begin
            if (callAck && callReq && callHigh)
                inServiceHigh <= 1'b1;
            if (callAck && callReq && !callHigh)
                inServiceLow <= 1'b1;
            // the core's return and divide times add up to the worst case
            if (instrDone)
                holdOff <= 1'b0;
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    a_basic_top_ones: assert property (
        sfrRd && sfrAddr == BASIC_PRIO_ADDR |=> sfrRdData[7:6] == 2'h3)
        else $error("basic level top bits not read as ones");

    a_ext0_level_map: assert property (
        wrBasic |=> arb.level[EXT0_BIT] == $past(sfrWrData[EXT0_BIT]))
        else $error("ext0 level bit not applied");

    a_high_blocks_all: assert property (
        inServiceHigh && !returnDone |=> !callReq)
        else $error("call raised during high service");

    a_low_only_high: assert property (
        inServiceLow && callReq |-> callHigh)
        else $error("low request nested into low service");

    a_detect_one_cycle: assert property (
        arb.found && !inServiceLow && !inServiceHigh && !holdOff
        && !callAck && !returnDone |=> callReq)
        else $error("request not raised one cycle after detect");

    a_high_first: assert property (
        callReq && $past(|(arb.req & arb.level)) |-> callHigh)
        else $error("low request chosen over high");

    a_tie_lowest: assert property (
        callReq && $past(arb.req[0]) && $past(arb.level[0]) == callHigh
        |-> callVector == VEC_BASE)
        else $error("tie not given to lowest order");

    a_vector_map: assert property (
        callReq |-> callVector == vector_of($past(arb.winIdx)))
        else $error("vector address wrong for winner");

    a_return_one_instr: assert property (
        returnDone |=> !callReq ##0 holdOff)
        else $error("call raised right after return");

    a_cmp_fall_flag: assert property (
        $fell(cmpOut[0]) |=> cmpFlags[0])
        else $error("falling edge flag not set");

    a_cmp_rise_flag: assert property (
        $rose(cmpOut[1]) |=> cmpFlags[3])
        else $error("rising edge flag not set");

    a_cmp_wake_idle: assert property (
        cmpFlags[1] && srcEnable[CMP_SRC_FIRST + 1] |=> wakeReq)
        else $error("comparator request did not wake");

    a_enable_gates: assert property (
        callReq |-> $past(arb.found))
        else $error("call without enabled pending request");

    a_call_drops_ack: assert property (
        callAck |=> !callReq)
        else $error("call still raised after it was taken");

    a_ext1_read_back: assert property (
        sfrRd && sfrAddr == EXT_PRIO1_ADDR
        |=> sfrRdData == $past(ext1Level))
        else $error("extended level register read wrong");

    a_unused_vector: assert property (
        callReq |-> callVector != vector_of(IDX_W'(UNUSED_SRC)))
        else $error("call raised to the unused vector");

    a_cmp1_fall_flag: assert property (
        $fell(cmpOut[1]) |=> cmpFlags[2])
        else $error("comparator 1 falling flag not set");

    a_cmp0_rise_flag: assert property (
        $rose(cmpOut[0]) |=> cmpFlags[1])
        else $error("comparator 0 rising flag not set");

    a_hold_until_instr: assert property (
        holdOff && !instrDone |=> holdOff)
        else $error("hold released before one instruction");

    a_wake_needs_flag: assert property (
        wakeReq |-> $past(|cmpFlags))
        else $error("wake raised without comparator request");

    c_low_call: cover property (
        callReq && !callHigh ##1 callAck);
    c_high_preempt: cover property (
        inServiceLow && callReq && callHigh);
    c_return_hold: cover property (
        returnDone ##1 holdOff ##[1:10] instrDone);
    c_pca_match: cover property (
        callReq && callVector == vector_of(IDX_W'(PCA_SRC)));
    c_cmp_wake: cover property (
        wakeReq && callReq);

endmodule

// >>> core/prio_pkg.sv
// constants, register map and vector helper for the interrupt prioritizer
package prio_pkg;

    // ***************************************************************
    // sources and vectors
    // ***************************************************************
    localparam int NUM_SRC = 22;
    localparam int IDX_W = 5;
    localparam int UNUSED_SRC = 20;
    localparam int PCA_SRC = 9;
    localparam int CMP_COUNT = 2;
    localparam int CMP_FLAGS = 4;
    localparam int CMP_SRC_FIRST = 10;
    localparam int PCA_MODULES_DEF = 5;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;

    // ***************************************************************
    // register map
    // ***************************************************************
    localparam logic [7:0] BASIC_PRIO_ADDR = 8'hb8;
    localparam logic [7:0] EXT_PRIO1_ADDR = 8'hf6;
    localparam logic [7:0] EXT_PRIO2_ADDR = 8'hf7;
    localparam logic [7:0] SVC_STATUS_ADDR = 8'hf8;
    localparam int BASIC_BITS = 6;
    localparam logic [1:0] BASIC_UNUSED_READ = 2'h3;
    localparam logic [5:0] BASIC_RESET = 6'h00;
    localparam logic [7:0] EXT_RESET = 8'h00;
    localparam int EXT0_BIT = 0;
    localparam int STAT_LOW_BIT = 0;
    localparam int STAT_HIGH_BIT = 1;
    localparam int STAT_HOLD_BIT = 2;

    // vector address of one arbitration position
    function automatic logic [15:0] vector_of(input logic [IDX_W-1:0] idx);
        vector_of = 16'(VEC_BASE + VEC_STEP * {11'h000, idx});
    endfunction

endpackage

// >>> core/arb_if.sv
// signals between the prioritizer and its fixed-order arbiter
`timescale 1ns/1ps
interface arb_if;
    import prio_pkg::*;
    logic [NUM_SRC-1:0] req;
    logic [NUM_SRC-1:0] level;
    logic found;
    logic winHigh;
    logic [IDX_W-1:0] winIdx;
    modport arbiter (input req, input level,
                     output found, output winHigh, output winIdx);
    modport client (output req, output level,
                    input found, input winHigh, input winIdx);
endinterface

// >>> core/vector_arbiter.sv
// two-level fixed-order arbiter over all interrupt sources
`timescale 1ns/1ps
module vector_arbiter
    import prio_pkg::*;
(
    arb_if.arbiter arb
);

    // ***************************************************************
    // level split and lowest-order pick
    // ***************************************************************
    wire logic [NUM_SRC-1:0] highReq;
    wire logic [NUM_SRC-1:0] lowReq;
    wire logic anyHigh;
    wire logic [NUM_SRC-1:0] pick;
    wire logic [IDX_W-1:0] chainIdx [NUM_SRC:0];

    assign highReq = arb.req & arb.level;
    assign lowReq = arb.req & ~arb.level;
    assign anyHigh = |highReq;
    // high level beats low level
    assign pick = anyHigh ? highReq : lowReq;
    assign chainIdx[NUM_SRC] = '0;

    // lowest set position wins a tie
    genvar i;
    generate
        for (i = 0; i < NUM_SRC; i++)
        begin : g_chain
            assign chainIdx[i] = pick[i] ? IDX_W'(i) : chainIdx[i + 1];
        end
    endgenerate

    assign arb.found = |arb.req;
    assign arb.winHigh = anyHigh;
    assign arb.winIdx = chainIdx[0];

endmodule

// >>> test/core_model.sv
// behavioural core: takes calls, returns, then runs one instruction
`timescale 1ns/1ps
module core_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic callReq,
    input wire logic ackOn,
    input wire logic retGo,
    output logic callAck,
    output logic returnDone,
    output logic instrDone
);
    // ****************
    // call and return
    // ****************
    localparam int RET_LEN = 5;
    localparam int DIV_LEN = 8;
    logic [3:0] cnt;
    logic [1:0] phase;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            callAck <= 1'b0;
            returnDone <= 1'b0;
            instrDone <= 1'b0;
            cnt <= 4'h0;
            phase <= 2'h0;
        end
        else
        begin
            callAck <= callReq && ackOn && !callAck;
            returnDone <= 1'b0;
            instrDone <= 1'b0;
            if (phase == 2'h0 && retGo)
            begin
                phase <= 2'h1;
                cnt <= 4'(RET_LEN - 1);
            end
            else if (phase != 2'h0 && cnt != 4'h0)
                cnt <= cnt - 4'h1;
            else if (phase == 2'h1)
            begin
                returnDone <= 1'b1;
                phase <= 2'h2;
                cnt <= 4'(DIV_LEN - 1);
            end
            else if (phase == 2'h2)
            begin
                instrDone <= 1'b1;
                phase <= 2'h0;
            end
        end
    end
endmodule

// >>> test/two_level_interrupt_prioritizer_test.sv
// self-checking bench for the two-level interrupt prioritizer
`timescale 1ns/1ps
module two_level_interrupt_prioritizer_test;
    import prio_pkg::*;
    logic mclk, reset_n, sfrWr, sfrRd, callAck, returnDone, instrDone;
    logic [7:0] sfrAddr, sfrWrData, sfrRdData;
    logic [NUM_SRC-1:0] srcPending, srcEnable;
    logic [PCA_MODULES_DEF-1:0] pcaMatch;
    logic [CMP_COUNT-1:0] cmpOut;
    logic [CMP_FLAGS-1:0] cmpFlagClear, cmpFlags;
    logic callReq, callHigh, wakeReq, inServiceLow, inServiceHigh;
    logic ackOn, retGo;
    logic [15:0] callVector;
    int error_cnt, check_count, cycles, bad;

    two_level_interrupt_prioritizer dut_u (.mclk, .reset_n, .sfrAddr,
        .sfrWrData, .sfrWr, .sfrRd, .sfrRdData, .srcPending, .srcEnable,
        .pcaMatch, .cmpOut, .cmpFlagClear, .callAck, .returnDone, .instrDone,
        .callReq, .callVector, .callHigh, .cmpFlags, .wakeReq,
        .inServiceLow, .inServiceHigh);
    core_model core_u (.mclk, .reset_n, .callReq, .ackOn, .retGo,
        .callAck, .returnDone, .instrDone);

    // ****************
    // helpers
    // ****************
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles >= 5000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(negedge mclk);
        sfrAddr = a;
        sfrWrData = d;
        sfrWr = 1'b1;
        @(negedge mclk);
        sfrWr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, exp);
        @(negedge mclk);
        sfrAddr = a;
        sfrRd = 1'b1;
        @(negedge mclk);
        sfrRd = 1'b0;
        chk("sfrRdData", {8'h00, sfrRdData}, {8'h00, exp});
    endtask

    task automatic wait_on(ref logic s, input int n);
        for (int i = 0; i < n && s !== 1'b1; i++)
            @(negedge mclk);
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic test_regs;
        rd(8'hb8, 8'hc0);
        rd(8'hf6, 8'h00);
        wr(8'hb8, 8'h15);
        rd(8'hb8, 8'hd5);
        wr(8'hf6, 8'ha5);
        rd(8'hf6, 8'ha5);
        rd(8'h00, 8'h00);
        wr(8'hf7, 8'h81);
        rd(8'hf7, 8'h81);
        wr(8'hf7, 8'h00);
        wr(8'hb8, 8'h00);
        wr(8'hf6, 8'h00);
    endtask

    task automatic test_arb;
        srcEnable = 22'h000003;
        srcPending = 22'h000003;
        step(1);
        chk("callReq", 16'(callReq), 16'h1);
        chk("callVector", callVector, 16'h0003);
        wr(8'hb8, 8'h02);
        step(2);
        chk("callVector", callVector, 16'h000b);
        chk("callHigh", 16'(callHigh), 16'h1);
        wr(8'hb8, 8'h01);
        step(2);
        chk("callVector", callVector, 16'h0003);
        srcEnable = 22'h000000;
        step(2);
        chk("callReq", 16'(callReq), 16'h0);
        srcPending = 22'h000000;
        wr(8'hb8, 8'h00);
    endtask

    task automatic test_nest;
        ackOn = 1'b1;
        srcEnable = 22'h000003;
        srcPending = 22'h000002;
        wait_on(inServiceLow, 20);
        srcPending = 22'h000000;
        chk("inServiceLow", 16'(inServiceLow), 16'h1);
        wr(8'hb8, 8'h01);
        srcPending = 22'h000001;
        wait_on(inServiceHigh, 20);
        srcPending = 22'h000002;
        chk("inServiceHigh", 16'(inServiceHigh), 16'h1);
        rd(8'hf8, 8'h03);
        step(6);
        chk("callReq", 16'(callReq), 16'h0);
        retGo = 1'b1;
        step(1);
        retGo = 1'b0;
        wait_on(instrDone, 30);
        step(3);
        chk("callReq", 16'(callReq), 16'h0);
        ackOn = 1'b0;
        retGo = 1'b1;
        step(1);
        retGo = 1'b0;
        bad = 0;
        for (int i = 0; i < 30 && instrDone !== 1'b1; i++)
        begin
            if (callReq !== 1'b0)
                bad++;
            step(1);
        end
        chk("early call", 16'(bad), 16'h0);
        wait_on(callReq, 3);
        chk("callVector", callVector, 16'h000b);
        srcPending = 22'h000000;
        wr(8'hb8, 8'h00);
    endtask

    task automatic test_cmp;
        srcEnable = 22'h000e00;
        cmpOut = 2'h1;
        step(1);
        chk("cmpFlags", 16'(cmpFlags), 16'h0002);
        step(1);
        chk("wakeReq", 16'(wakeReq), 16'h1);
        chk("callVector", callVector, 16'h005b);
        cmpOut = 2'h0;
        step(1);
        chk("cmpFlags", 16'(cmpFlags), 16'h0003);
        step(1);
        chk("callVector", callVector, 16'h0053);
        cmpFlagClear = 4'hf;
        step(1);
        cmpFlagClear = 4'h0;
        pcaMatch = 5'h04;
        step(2);
        chk("callVector", callVector, 16'h004b);
        chk("cmpFlags", 16'(cmpFlags), 16'h0000);
        cmpOut = 2'h2;
        step(1);
        chk("cmpFlags", 16'(cmpFlags), 16'h0008);
        cmpOut = 2'h0;
        cmpFlagClear = 4'h8;
        step(1);
        cmpFlagClear = 4'h0;
        chk("cmpFlags", 16'(cmpFlags), 16'h0004);
        chk("wakeReq", 16'(wakeReq), 16'h0);
        cmpFlagClear = 4'hf;
        step(1);
        cmpFlagClear = 4'h0;
        pcaMatch = 5'h00;
        srcEnable = 22'h000000;
    endtask

    task automatic end_sim;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        reset_n = 1'b0;
        {sfrWr, sfrRd, ackOn, retGo} = 4'h0;
        sfrAddr = 8'h00;
        sfrWrData = 8'h00;
        srcPending = 22'h000000;
        srcEnable = 22'h000000;
        pcaMatch = 5'h00;
        cmpOut = 2'h0;
        cmpFlagClear = 4'h0;
        step(8);
        chk("callVector", callVector, 16'h0000);
        reset_n = 1'b1;
        test_regs();
        test_arb();
        test_nest();
        test_cmp();
        end_sim();
    end
endmodule
